/* rtl/iso_core.sv */
// Decode and execute of indexed bit set and set all ones instructions
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - In indexed mode the bit set opcode sets bit b of the byte at base pointer plus k only.
// - The bit set form takes offsets 0 to 95 and bit numbers 0 to 7 from its opcode fields.
// - The set all opcode 0x68 writes FFh to the byte at base pointer plus k, no flags touched.
// - With the extended set enable bit at zero the opcodes use plain direct addressing.
// - The operand is an offset only when it is at most 5Fh and the access bank bit is zero.
module iso_core
	import iso_pkg::*;
(
	input wire logic MCLK_I,
	input wire logic ARST_N_I,
	input wire logic EXT_SET_EN_I,
	input wire logic [OPC_W-1:0] OPCODE_I,
	input wire logic [ADDR_W-1:0] FRAME_BASE_I,
	input wire logic [ADDR_W-1:0] DIRECT_BASE_I,
	input wire logic [DATA_W-1:0] MEM_RDATA_I,
	output var logic MEM_RE_O,
	output var logic MEM_WE_O,
	output var logic [ADDR_W-1:0] MEM_ADDR_O,
	output var logic [DATA_W-1:0] MEM_WDATA_O,
	output var logic [3:0] PHASE_O
);
	iso_phase_t phase_reg;
	iso_phase_t phase_next;
	iso_op_t op_reg;
	iso_mem_req_t req_reg;
	iso_mem_req_t req_next;
	logic [DATA_W-1:0] data_reg;
	logic [DATA_W-1:0] data_next;
	logic [2:0] bit_reg;

	// Field helpers
	function automatic logic [DATA_W-1:0] bit_mask(input logic [2:0] b);
		bit_mask = 8'h01 << b;
	endfunction

	function automatic logic [ADDR_W-1:0] eff_addr(input logic [ADDR_W-1:0] b,
		input logic [7:0] k);
		eff_addr = b + {{(ADDR_W-8){1'b0}}, k};
	endfunction

	// Decode
	wire logic [7:0] operand = OPCODE_I[7:0];
	wire logic abank = OPCODE_I[ABANK_POS];
	wire logic [2:0] bit_num = OPCODE_I[BIT_LSB +: 3];
	wire logic is_bset = OPCODE_I[15:12] == OPC_BSET_HI;
	// Access bank bit is bit 8 in both forms, so set all decodes without it
	wire logic is_setall = OPCODE_I[15:9] == OPC_SETALL_HI[7:1];
	// Config bit is static after programming; a late copy would misaddress the first op
	wire logic indexed = EXT_SET_EN_I && !abank && (operand <= OFST_MAX);
	wire logic [ADDR_W-1:0] base = indexed ? FRAME_BASE_I : DIRECT_BASE_I;
	wire logic [ADDR_W-1:0] ea = eff_addr(base, operand);
	wire iso_op_t dec_op = is_setall ? OP_SETALL : (is_bset ? OP_BSET : OP_NONE);

	always_comb begin
		phase_next = PH_Q1;
		req_next = req_reg;
		data_next = data_reg;
		req_next.we = 1'b0;
		req_next.re = 1'b0;
		case (phase_reg)
			PH_Q1: begin
				phase_next = PH_Q2;
				req_next.addr = ea;
				req_next.re = dec_op != OP_NONE;
			end
			PH_Q2: begin
				phase_next = PH_Q3;
				data_next = MEM_RDATA_I;
			end
			PH_Q3: begin
				phase_next = PH_Q4;
				// Other bits kept, flags never touched
				if (op_reg == OP_BSET) begin
					req_next.wdata = data_reg | bit_mask(bit_reg);
				end else begin
					req_next.wdata = ALL_ONES;
				end
				req_next.we = op_reg != OP_NONE;
			end
			PH_Q4: begin
				phase_next = PH_Q1;
			end
			default: begin
				phase_next = PH_Q1;
			end
		endcase
	end

	// Phase ring
	always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			phase_reg <= PH_Q1;
		end else begin
			phase_reg <= phase_next;
		end
	end

	// Strobes last one phase, address and data hold
	always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			req_reg <= '0;
		end else begin
			req_reg <= req_next;
		end
	end

	// Target byte taken at the end of the read phase
	always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			data_reg <= DATA_RST;
		end else begin
			data_reg <= data_next;
		end
	end

	// Latched at decode so later phases never look at the opcode
	always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			op_reg <= OP_NONE;
			bit_reg <= 3'h0;
		end else if (phase_reg == PH_Q1) begin
			op_reg <= dec_op;
			bit_reg <= bit_num;
		end
	end

	assign MEM_RE_O = req_reg.re;
	assign MEM_WE_O = req_reg.we;
	assign MEM_ADDR_O = req_reg.addr;
	assign MEM_WDATA_O = req_reg.wdata;
	assign PHASE_O = phase_reg;

	phase_ring_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
		phase_reg == PH_Q1 |=> phase_reg == PH_Q2 ##1 phase_reg == PH_Q3 ##1 phase_reg == PH_Q4)
		else $error("phase ring broken");

	read_q2_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
		MEM_RE_O |-> phase_reg == PH_Q2)
		else $error("read strobe outside the read phase");

	write_q4_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
		MEM_WE_O |-> phase_reg == PH_Q4 && $past(MEM_RE_O, 2))
		else $error("write without read two cycles before");

	read_write_pair_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
		MEM_RE_O |-> ##2 MEM_WE_O)
		else $error("read not followed by its write");

	strobe_pulse_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
		MEM_RE_O || MEM_WE_O |=> !MEM_RE_O && !MEM_WE_O)
		else $error("strobe longer than one phase");

	setall_data_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
		MEM_WE_O && op_reg == OP_SETALL |-> MEM_WDATA_O == ALL_ONES)
		else $error("set all wrote wrong value");

	bset_data_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
		MEM_WE_O && op_reg == OP_BSET |-> MEM_WDATA_O == ($past(MEM_RDATA_I, 2)
		| bit_mask(bit_reg)))
		else $error("bit set altered other bits");

	bset_bit_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
		MEM_WE_O && op_reg == OP_BSET |-> MEM_WDATA_O[bit_reg] == 1'b1)
		else $error("selected bit not set");

	addr_hold_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
		MEM_RE_O |=> ##2 MEM_ADDR_O == $past(MEM_ADDR_O, 3))
		else $error("write address differs from read");

	addr_stable_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
		phase_reg != PH_Q2 |-> $stable(MEM_ADDR_O))
		else $error("address moved outside decode");

	wdata_stable_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
		phase_reg != PH_Q4 |-> $stable(MEM_WDATA_O))
		else $error("write data moved outside process");

	op_hold_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
		phase_reg != PH_Q1 |=> $stable(op_reg) && $stable(bit_reg))
		else $error("operation changed inside an instruction");

	index_addr_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
		phase_reg == PH_Q1 && indexed && dec_op != OP_NONE |=>
		MEM_ADDR_O == $past(FRAME_BASE_I) + {4'h0, $past(operand)})
		else $error("indexed address wrong");

	offset_limit_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
		phase_reg == PH_Q1 && EXT_SET_EN_I && dec_op != OP_NONE
		&& (abank || operand > OFST_MAX) |=>
		MEM_ADDR_O == $past(DIRECT_BASE_I) + {4'h0, $past(operand)})
		else $error("out of range operand not direct");

	direct_addr_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
		phase_reg == PH_Q1 && !EXT_SET_EN_I && dec_op != OP_NONE |=>
		MEM_ADDR_O == $past(DIRECT_BASE_I) + {4'h0, $past(operand)})
		else $error("direct address wrong");

	no_op_idle_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
		phase_reg == PH_Q1 && dec_op == OP_NONE |=> !MEM_RE_O ##2 !MEM_WE_O)
		else $error("access on unknown opcode");

	bset_cov: cover property (@(posedge MCLK_I) disable iff (!ARST_N_I)
		MEM_WE_O && op_reg == OP_BSET);

	setall_cov: cover property (@(posedge MCLK_I) disable iff (!ARST_N_I)
		MEM_WE_O && op_reg == OP_SETALL);

	direct_cov: cover property (@(posedge MCLK_I) disable iff (!ARST_N_I)
		phase_reg == PH_Q1 && !indexed && dec_op != OP_NONE);

	top_offset_cov: cover property (@(posedge MCLK_I) disable iff (!ARST_N_I)
		phase_reg == PH_Q1 && indexed && operand == OFST_MAX && dec_op != OP_NONE);

	no_op_cov: cover property (@(posedge MCLK_I) disable iff (!ARST_N_I)
		phase_reg == PH_Q1 && dec_op == OP_NONE);
endmodule

`default_nettype wire

/* rtl/iso_pkg.sv */
// Package for the indexed offset set instruction block
package iso_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 12;
	localparam int OPC_W = 16;
	// Opcode fields
	localparam logic [3:0] OPC_BSET_HI = 4'h8;
	localparam logic [7:0] OPC_SETALL_HI = 8'h68;
	localparam int BIT_LSB = 9;
	localparam int ABANK_POS = 8;
	localparam logic [7:0] OFST_MAX = 8'h5F;
	localparam logic [7:0] ALL_ONES = 8'hFF;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;

	typedef enum logic [3:0] {
		PH_Q1 = 4'b0001,
		PH_Q2 = 4'b0010,
		PH_Q3 = 4'b0100,
		PH_Q4 = 4'b1000
	} iso_phase_t;

	typedef enum logic [1:0] {
		OP_NONE = 2'h0,
		OP_BSET = 2'h1,
		OP_SETALL = 2'h2
	} iso_op_t;

	typedef struct packed {
		logic we;
		logic re;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} iso_mem_req_t;
endpackage

/* test/tb.sv */
// Row-driven testbench for the indexed offset set block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import iso_pkg::*;
	typedef struct packed {
		logic e;
		logic [15:0] o;
		logic [11:0] f;
		logic [7:0] r;
		logic w;
		logic [11:0] a;
		logic [7:0] d;
	} iso_row_t;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic ext_en = 1'b0;
	logic [OPC_W-1:0] opc = '0;
	logic [ADDR_W-1:0] fb = '0;
	logic [ADDR_W-1:0] db = 12'h100;
	logic [DATA_W-1:0] rd = '0;
	logic re, we;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wd;
	logic [3:0] ph;
	int n_fail = 0;
	int check_count = 0;
	// Direct base 100h keeps direct addresses the same under add or concatenation
	iso_row_t rows [9] = '{
		'{1'b1, 16'h8E0A, 12'hA00, 8'h55, 1'b1, 12'hA0A, 8'hD5},
		'{1'b1, 16'h805F, 12'hA00, 8'h80, 1'b1, 12'hA5F, 8'h81},
		'{1'b1, 16'h682C, 12'hA00, 8'h00, 1'b1, 12'hA2C, 8'hFF},
		'{1'b1, 16'h8660, 12'hA00, 8'h00, 1'b1, 12'h160, 8'h08},
		'{1'b1, 16'h810A, 12'hA00, 8'hF0, 1'b1, 12'h10A, 8'hF1},
		'{1'b0, 16'h8E0A, 12'hA00, 8'h55, 1'b1, 12'h10A, 8'hD5},
		'{1'b0, 16'h682C, 12'hA00, 8'h00, 1'b1, 12'h12C, 8'hFF},
		'{1'b1, 16'h692C, 12'hA00, 8'h00, 1'b1, 12'h12C, 8'hFF},
		'{1'b1, 16'h0000, 12'hA00, 8'h00, 1'b0, 12'h000, 8'h00}};
	always #2.5 mclk = ~mclk;
	iso_core dut_u (.MCLK_I(mclk), .ARST_N_I(arst_n), .EXT_SET_EN_I(ext_en), .OPCODE_I(opc),
		.FRAME_BASE_I(fb), .DIRECT_BASE_I(db), .MEM_RDATA_I(rd), .MEM_RE_O(re), .MEM_WE_O(we),
		.MEM_ADDR_O(addr), .MEM_WDATA_O(wd), .PHASE_O(ph));
	task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic report_and_stop;
		if (n_fail == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Called 1 ns after an edge that left the phase at Q1
	task automatic run(input iso_row_t r);
		ext_en = r.e;
		opc = r.o;
		fb = r.f;
		rd = r.r;
		@(posedge mclk) #1;
		chk("re", {11'h000, r.w}, {11'h000, re});
		if (r.w) chk("addr", r.a, addr);
		@(posedge mclk) #1;
		// Read data is stale after Q2, so show garbage rather than hold it
		rd = ~r.r;
		@(posedge mclk) #1;
		chk("we", {11'h000, r.w}, {11'h000, we});
		if (r.w) chk("wdata", {4'h0, r.d}, {4'h0, wd});
		@(posedge mclk) #1;
	endtask
	initial begin
		repeat (20) @(posedge mclk);
		#1 arst_n = 1'b1;
		chk("phase", 12'h001, {8'h00, ph});
		for (int i = 0; i < 9; i++) run(rows[i]);
		for (int b = 0; b < 8; b++) run('{1'b1, {4'h8, 3'(b), 9'h000}, 12'hA00, 8'h00, 1'b1,
			12'hA00, 8'h01 << b});
		// Reset in the middle of an instruction must kill the write
		run('{1'b1, 16'h8E0A, 12'hA00, 8'h55, 1'b1, 12'hA0A, 8'hD5});
		@(posedge mclk) #1;
		arst_n = 1'b0;
		opc = 16'h0000;
		#1;
		chk("rst phase", 12'h001, {8'h00, ph});
		chk("rst we", 12'h000, {11'h000, we});
		chk("rst addr", 12'h000, addr);
		chk("rst wdata", 12'h000, {4'h0, wd});
		@(posedge mclk) #1;
		arst_n = 1'b1;
		// Killed write must not come back after release
		repeat (4) begin
			@(posedge mclk) #1;
			chk("killed we", 12'h000, {11'h000, we});
		end
		run(rows[2]);
		report_and_stop;
	end
	initial begin
		#5000;
		n_fail++;
		report_and_stop;
	end
endmodule
`default_nettype wire
